/* File: i2cm_defs.vh */
// Purpose: constants for the i2c master sequencer (register map, fields, resets)
// Assumes: 8-bit register bus, byte addresses 0..5
// Notes: included by i2cm_core.v
//
// Function
// - receive enable write is ignored unless the module is idle
// - while receiving, toggle SCL each counter rollover and shift in SDA
// - after eighth falling clock: clear enable, load buffer, set full and irq
// - a buffer read outside transmit clears the full flag; moving a byte sets it
// - full byte received while buffer still full sets the overflow flag
// - buffer write during receive, ack or stop sets write collision, no store
// - ack enable pulls SCL low and drives the ack data level on SDA
// - ack: release SCL after one period, count once high, pull low, go idle
// - stop: drive SDA low, once low count, release SCL, then SDA
// - SDA high with SCL high sets stop seen; a period later irq and done
// - reset disables the module and abandons any transfer
// - start and stop seen flags clear on reset and while disabled
// - bus busy with interrupt enabled: a foreign stop raises the irq flag
// - released SDA sampled low while SCL high in a transmitted byte is a collision
// - transmit collision halts, clears full, releases lines, allows writes
// - collision in start, restart or ack aborts it and clears enable
// - start with a line low, or SCL low in first count, is a collision
// - SDA low in first start count restarts counter and drives SDA early
// - restart: release SCL after count; SDA low once SCL high is collision
// - restart count: SCL falling before SDA asserted is a collision
// - restart timeout with both high: drive SDA low, count, then SCL low
// - every counter period reloads from the reload value
`ifndef I2CM_DEFS_VH
`define I2CM_DEFS_VH
`define I2CM_A_CTRL1 3'h0
`define I2CM_A_CTRL2 3'h1
`define I2CM_A_STAT 3'h2
`define I2CM_A_BUF 3'h3
`define I2CM_A_RELOAD 3'h4
`define I2CM_A_FLAGS 3'h5
`define I2CM_B_WRITE_COLLISION_FLAG 7
`define I2CM_B_OVF 6
`define I2CM_B_MODEN 5
`define I2CM_B_IRQEN 0
`define I2CM_B_ACK_STATUS_FLAG 6
`define I2CM_B_ACK_DATA_VALUE 5
`define I2CM_B_ACK_SEQUENCE_ENABLE 4
`define I2CM_B_RECEIVE_ENABLE_BIT 3
`define I2CM_B_PEN 2
`define I2CM_B_REPEAT_START_ENABLE 1
`define I2CM_B_SEN 0
`define I2CM_B_STOPSEEN 4
`define I2CM_B_STARTSEEN 3
`define I2CM_B_BUSY 2
`define I2CM_B_BF 0
`define I2CM_B_BCOL 3
`define I2CM_B_SIRQ 0
`define I2CM_RELOAD_RST 8'h09
`define I2CM_LAST_BIT 4'h7
`define I2CM_ACK_BIT 4'h8
`endif

/* File: i2cm_core.v */
// Purpose: i2c master sequencer: start, restart, byte tx/rx, ack, stop, arbitration
// Assumes: clk_sys_i at 250 MHz, synchronous active-high reset, open-drain pins
// Notes: one counter period is reload+1 clock cycles; oe_n low pulls a line low
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_defs.vh"
module i2cm_core (
  // clock and reset
  input wire clk_sys_i,
  input wire srst_i,
  // register port
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // bus pins
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n_o,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_n_o
);
  // ****************************************
  // states
  // ****************************************
  localparam [4:0] S_IDLE = 5'h00;
  localparam [4:0] S_ST1 = 5'h01;
  localparam [4:0] S_ST2 = 5'h02;
  localparam [4:0] S_RS1 = 5'h03;
  localparam [4:0] S_RS2 = 5'h04;
  localparam [4:0] S_RS3 = 5'h05;
  localparam [4:0] S_RS4 = 5'h06;
  localparam [4:0] S_RS5 = 5'h07;
  localparam [4:0] S_TXL = 5'h08;
  localparam [4:0] S_TXH = 5'h09;
  localparam [4:0] S_RXL = 5'h0A;
  localparam [4:0] S_RXH = 5'h0B;
  localparam [4:0] S_AKL = 5'h0C;
  localparam [4:0] S_AKH = 5'h0D;
  localparam [4:0] S_SP1 = 5'h0E;
  localparam [4:0] S_SP2 = 5'h0F;
  localparam [4:0] S_SP3 = 5'h10;
  localparam [4:0] S_SP4 = 5'h11;
  localparam [4:0] S_SP5 = 5'h12;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg sda_m, sda_s, scl_m, scl_s, sda_p;
  always @(posedge clk_sys_i) begin
    sda_m <= sda_i;
    sda_s <= sda_m;
    scl_m <= scl_i;
    scl_s <= scl_m;
    sda_p <= sda_s;
  end

  // ****************************************
  // state and registers
  // ****************************************
  reg [4:0] state;
  reg [7:0] cnt, reload, shift, buffer;
  reg [3:0] bitcnt;
  reg mod_en, irq_en, write_collision_flag, ovf, bf, ack_stat, ack_dt;
  reg ack_en, receive_enable_bit, stop_enable, repeat_start_enable, start_enable;
  reg start_seen, stop_seen, sirq, bcol, hi_seen;
  wire tick = (cnt == 8'h00);
  wire busy = (state != S_IDLE) | ack_en | receive_enable_bit | stop_enable | repeat_start_enable | start_enable;

  // collision: flag it, free both lines, drop every sequence enable
  task do_coll;
    begin
      bcol <= 1'b1;
      sda_oe_n_o <= 1'b1;
      scl_oe_n_o <= 1'b1;
      start_enable <= 1'b0;
      repeat_start_enable <= 1'b0;
      stop_enable <= 1'b0;
      ack_en <= 1'b0;
      receive_enable_bit <= 1'b0;
      state <= S_IDLE;
    end
  endtask

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      reload <= `I2CM_RELOAD_RST;
      shift <= 8'h00;
      buffer <= 8'h00;
      bitcnt <= 4'h0;
      mod_en <= 1'b0;
      irq_en <= 1'b0;
      write_collision_flag <= 1'b0;
      ovf <= 1'b0;
      bf <= 1'b0;
      ack_stat <= 1'b0;
      ack_dt <= 1'b0;
      ack_en <= 1'b0;
      receive_enable_bit <= 1'b0;
      stop_enable <= 1'b0;
      repeat_start_enable <= 1'b0;
      start_enable <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      sirq <= 1'b0;
      bcol <= 1'b0;
      hi_seen <= 1'b0;
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      scl_oe_n_o <= 1'b1;
      rdata_o <= 8'h00;
    end else begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
      // ****************************************
      // software writes (hardware sets below win)
      // ****************************************
      if (wr_i) begin
        case (addr_i)
          `I2CM_A_CTRL1: begin
            write_collision_flag <= wdata_i[`I2CM_B_WRITE_COLLISION_FLAG];
            ovf <= wdata_i[`I2CM_B_OVF];
            mod_en <= wdata_i[`I2CM_B_MODEN];
            irq_en <= wdata_i[`I2CM_B_IRQEN];
          end
          `I2CM_A_CTRL2: begin
            ack_dt <= wdata_i[`I2CM_B_ACK_DATA_VALUE];
            if (!busy) begin
              ack_en <= wdata_i[`I2CM_B_ACK_SEQUENCE_ENABLE];
              receive_enable_bit <= wdata_i[`I2CM_B_RECEIVE_ENABLE_BIT];
              stop_enable <= wdata_i[`I2CM_B_PEN];
              repeat_start_enable <= wdata_i[`I2CM_B_REPEAT_START_ENABLE];
              start_enable <= wdata_i[`I2CM_B_SEN];
            end
          end
          `I2CM_A_BUF: begin
            if (busy) begin
              write_collision_flag <= 1'b1;
            end else begin
              shift <= wdata_i;
              buffer <= wdata_i;
              bf <= 1'b1;
              bitcnt <= 4'h0;
              scl_oe_n_o <= 1'b0;
              cnt <= reload;
              state <= S_TXL;
            end
          end
          `I2CM_A_RELOAD: begin
            reload <= wdata_i;
          end
          `I2CM_A_FLAGS: begin
            if (wdata_i[`I2CM_B_BCOL])
              bcol <= 1'b0;
            if (wdata_i[`I2CM_B_SIRQ])
              sirq <= 1'b0;
          end
          default: begin
          end
        endcase
      end
      if (rd_i && addr_i == `I2CM_A_BUF && state != S_TXL && state != S_TXH)
        bf <= 1'b0;
      // ****************************************
      // read data, valid the cycle after the strobe
      // ****************************************
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `I2CM_A_CTRL1: rdata_o <= {write_collision_flag, ovf, mod_en, 4'h0, irq_en};
          `I2CM_A_CTRL2: rdata_o <= {1'b0, ack_stat, ack_dt, ack_en, receive_enable_bit, stop_enable, repeat_start_enable, start_enable};
          `I2CM_A_STAT: rdata_o <= {3'h0, stop_seen, start_seen, busy, 1'b0, bf};
          `I2CM_A_BUF: rdata_o <= buffer;
          `I2CM_A_RELOAD: rdata_o <= reload;
          `I2CM_A_FLAGS: rdata_o <= {4'h0, bcol, 2'h0, sirq};
          default: rdata_o <= 8'h00;
        endcase
      end
      // ****************************************
      // bus monitor for start and stop
      // ****************************************
      if (scl_s && sda_p && !sda_s) begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
      end
      if (scl_s && !sda_p && sda_s) begin
        stop_seen <= 1'b1;
        start_seen <= 1'b0;
        if (irq_en && state != S_SP4 && state != S_SP5)
          sirq <= 1'b1;
      end
      // ****************************************
      // sequencer
      // ****************************************
      case (state)
        S_IDLE: begin
          if (start_enable) begin
            if (!sda_s || !scl_s) begin
              do_coll;
            end else begin
              sda_oe_n_o <= 1'b1;
              scl_oe_n_o <= 1'b1;
              cnt <= reload;
              state <= S_ST1;
            end
          end else if (repeat_start_enable) begin
            scl_oe_n_o <= 1'b0;
            state <= S_RS1;
          end else if (stop_enable) begin
            sda_oe_n_o <= 1'b0;
            state <= S_SP1;
          end else if (receive_enable_bit) begin
            sda_oe_n_o <= 1'b1;
            scl_oe_n_o <= 1'b0;
            bitcnt <= 4'h0;
            cnt <= reload;
            state <= S_RXL;
          end else if (ack_en) begin
            scl_oe_n_o <= 1'b0;
            sda_oe_n_o <= ack_dt;
            hi_seen <= 1'b0;
            cnt <= reload;
            state <= S_AKL;
          end
        end
        S_ST1: begin
          if (!sda_s) begin
            sda_oe_n_o <= 1'b0;
            cnt <= reload;
            state <= S_ST2;
          end else if (!scl_s) begin
            do_coll;
          end else if (tick) begin
            sda_oe_n_o <= 1'b0;
            cnt <= reload;
            state <= S_ST2;
          end
        end
        S_ST2: begin
          if (tick) begin
            scl_oe_n_o <= 1'b0;
            start_enable <= 1'b0;
            sirq <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_RS1: begin
          cnt <= reload;
          if (!scl_s) begin
            sda_oe_n_o <= 1'b1;
            state <= S_RS2;
          end
        end
        S_RS2: begin
          if (tick) begin
            if (sda_s) begin
              scl_oe_n_o <= 1'b1;
              state <= S_RS3;
            end else begin
              do_coll;
            end
          end
        end
        S_RS3: begin
          cnt <= reload;
          if (scl_s) begin
            if (!sda_s)
              do_coll;
            else
              state <= S_RS4;
          end
        end
        S_RS4: begin
          if (!scl_s && sda_s) begin
            do_coll;
          end else if (tick) begin
            sda_oe_n_o <= 1'b0;
            cnt <= reload;
            state <= S_RS5;
          end
        end
        S_RS5: begin
          if (tick) begin
            scl_oe_n_o <= 1'b0;
            repeat_start_enable <= 1'b0;
            sirq <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_TXL: begin
          sda_oe_n_o <= (bitcnt == `I2CM_ACK_BIT) ? 1'b1 : shift[7];
          if (tick) begin
            scl_oe_n_o <= 1'b1;
            cnt <= reload;
            state <= S_TXH;
          end
        end
        S_TXH: begin
          if (!scl_s) begin
            cnt <= reload;
          end else if (bitcnt != `I2CM_ACK_BIT && sda_oe_n_o && !sda_s) begin
            do_coll;
            bf <= 1'b0;
          end else if (tick) begin
            scl_oe_n_o <= 1'b0;
            cnt <= reload;
            bitcnt <= bitcnt + 4'h1;
            shift <= {shift[6:0], 1'b0};
            if (bitcnt == `I2CM_LAST_BIT)
              bf <= 1'b0;
            if (bitcnt == `I2CM_ACK_BIT) begin
              ack_stat <= sda_s;
              sirq <= 1'b1;
              state <= S_IDLE;
            end else begin
              state <= S_TXL;
            end
          end
        end
        S_RXL: begin
          if (tick) begin
            scl_oe_n_o <= 1'b1;
            cnt <= reload;
            state <= S_RXH;
          end
        end
        S_RXH: begin
          if (!scl_s) begin
            cnt <= reload;
          end else if (tick) begin
            scl_oe_n_o <= 1'b0;
            cnt <= reload;
            shift <= {shift[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
            state <= S_RXL;
            if (bitcnt == `I2CM_LAST_BIT) begin
              buffer <= {shift[6:0], sda_s};
              if (bf)
                ovf <= 1'b1;
              bf <= 1'b1;
              sirq <= 1'b1;
              receive_enable_bit <= 1'b0;
              cnt <= 8'h00;
              state <= S_IDLE;
            end
          end
        end
        S_AKL: begin
          if (tick) begin
            scl_oe_n_o <= 1'b1;
            cnt <= reload;
            state <= S_AKH;
          end
        end
        S_AKH: begin
          if (!scl_s && !hi_seen) begin
            cnt <= reload;
          end else if (ack_dt && !sda_s) begin
            do_coll;
          end else begin
            hi_seen <= 1'b1;
            if (tick) begin
              scl_oe_n_o <= 1'b0;
              ack_en <= 1'b0;
              sirq <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_SP1: begin
          cnt <= reload;
          if (!sda_s)
            state <= S_SP2;
        end
        S_SP2: begin
          if (tick) begin
            scl_oe_n_o <= 1'b1;
            cnt <= reload;
            state <= S_SP3;
          end
        end
        S_SP3: begin
          if (!scl_s) begin
            cnt <= reload;
          end else if (tick) begin
            sda_oe_n_o <= 1'b1;
            state <= S_SP4;
          end
        end
        S_SP4: begin
          cnt <= reload;
          if (sda_s && scl_s)
            state <= S_SP5;
        end
        S_SP5: begin
          if (tick) begin
            stop_enable <= 1'b0;
            sirq <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      // ****************************************
      // module disabled: everything idle
      // ****************************************
      if (!mod_en) begin
        state <= S_IDLE;
        cnt <= 8'h00;
        sda_oe_n_o <= 1'b1;
        scl_oe_n_o <= 1'b1;
        ack_en <= 1'b0;
        receive_enable_bit <= 1'b0;
        stop_enable <= 1'b0;
        repeat_start_enable <= 1'b0;
        start_enable <= 1'b0;
        start_seen <= 1'b0;
        stop_seen <= 1'b0;
      end
    end
  end
endmodule // i2cm_core
`default_nettype wire

/* File: i2cm_sva.sv */
// Purpose: port-level checks for the i2c master sequencer
// Assumes: bound to i2cm_core, reload value of 3 or more
// Notes: sees only the core's ports
`timescale 1ns/1ps
`default_nettype none
module i2cm_sva (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // bus pins
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // ************************************************************
  // assertions
  // ************************************************************
  a_sda_low_only:
    assert property (sda_o == 1'b0) else $error("sda driven high");
  a_scl_low_only:
    assert property (scl_o == 1'b0) else $error("scl driven high");
  a_reset_release:
    assert property (disable iff (1'b0) srst_i |=> sda_oe_n_o && scl_oe_n_o)
    else $error("lines not released by reset");
  a_reset_flags:
    assert property ($past(srst_i) && rd_i && addr_i == 3'h2 |=> rdata_o == 8'h00)
    else $error("status not clear after reset");
  a_rx_clock_start:
    assert property (wr_i && addr_i == 3'h1 && wdata_i[3] |-> ##[1:4] !scl_oe_n_o)
    else $error("scl not pulled for receive");
  a_ack_drive:
    assert property (wr_i && addr_i == 3'h1 && wdata_i[5:4] == 2'b01 |-> ##[1:4] !sda_oe_n_o && !scl_oe_n_o)
    else $error("ack level not driven");
  a_stop_sda_low:
    assert property (wr_i && addr_i == 3'h1 && wdata_i[2] |-> ##[1:4] !sda_oe_n_o)
    else $error("stop did not pull sda");
  a_scl_high_min:
    assert property ($rose(scl_oe_n_o) |=> scl_oe_n_o [*3]) else $error("scl high phase too short");
  a_scl_low_min:
    assert property ($fell(scl_oe_n_o) |=> !scl_oe_n_o [*3]) else $error("scl low phase too short");
  c_rx: cover property (wr_i && addr_i == 3'h1 && wdata_i[3]);
  c_ack: cover property (wr_i && addr_i == 3'h1 && wdata_i[4]);
  c_stop: cover property (wr_i && addr_i == 3'h1 && wdata_i[2]);
endmodule // i2cm_sva
`default_nettype wire

/* File: i2cm_slave_model.sv */
// Purpose: slave and rival-master model on the open-drain bus
// Assumes: lines pulled up in the bench
// Notes: data changes on each scl fall and is released after eight bits
`timescale 1ns/1ps
`default_nettype none
module i2cm_slave_model (
  // bus lines
  input wire logic scl_i,
  output logic sda_oe_n_o,
  output logic scl_oe_n_o,
  // bench control
  input wire logic load_i,
  input wire logic [7:0] byte_i,
  input wire logic force_sda_i,
  input wire logic force_scl_i
);
  int cnt = 8;
  logic drv = 1'b1;
  // ************************************************************
  // byte sender
  // ************************************************************
  always @(posedge load_i or negedge scl_i) begin
    if (load_i) begin
      cnt <= scl_i ? 0 : 1;
      drv <= scl_i | byte_i[7];
    end else if (cnt < 8) begin
      drv <= byte_i[7 - cnt];
      cnt <= cnt + 1;
    end else begin
      drv <= 1'b1;
    end
  end
  // rival master pulls a line low on command
  assign sda_oe_n_o = drv & ~force_sda_i;
  assign scl_oe_n_o = ~force_scl_i;
endmodule // i2cm_slave_model
`default_nettype wire

/* File: i2cm_core_tb.sv */
// Purpose: self-checking bench for the i2c master sequencer
// Assumes: pulled-up lines, one slave model
// Notes: reload 4 keeps bus periods short
`timescale 1ns/1ps
`default_nettype none
module i2cm_core_tb;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ld = 1'b0;
  logic fsda = 1'b0;
  logic fscl = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] sbyte = 8'h00;
  logic [7:0] v;
  logic [7:0] tbl [3] = '{8'hA5, 8'h5A, 8'hC3};
  wire [7:0] rdata_o;
  wire sda_o, scl_o, sda_oe_n, scl_oe_n, m_sda, m_scl;
  wire sda_w = sda_oe_n & m_sda;
  wire scl_w = scl_oe_n & m_scl;
  int fails = 0;
  int check_count = 0;
  int i;
  i2cm_core i_i2cm_core (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n));
  i2cm_slave_model i_i2cm_slave_model (.scl_i(scl_w), .sda_oe_n_o(m_sda), .scl_oe_n_o(m_scl),
    .load_i(ld), .byte_i(sbyte), .force_sda_i(fsda), .force_scl_i(fscl));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(v & m, e);
  endtask
  // polls a register field, bounded
  task automatic wt(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    for (int j = 0; j < 3000; j++) begin
      rd(a);
      if ((v & m) === e) return;
    end
    fails++;
    $display("unexpected at %0t: wait timed out", $time);
    print_verdict();
  endtask
  task automatic lines(input logic [1:0] e);
    chk({6'h00, sda_oe_n, scl_oe_n}, {6'h00, e});
  endtask
  // ************************************************************
  // stimulus
  // ************************************************************
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    addr_i <= 3'h2;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, 8'h00);
    rchk(3'h4, 8'hFF, 8'h09);
    rchk(3'h0, 8'hFF, 8'h00);
    wr(3'h7, 8'hFF);
    rchk(3'h7, 8'hFF, 8'h00);
    $display("test reset done");
    wr(3'h0, 8'h21);
    wr(3'h4, 8'h04);
    for (i = 0; i < 3; i++) begin
      wt(3'h1, 8'h1F, 8'h00);
      sbyte <= tbl[i];
      ld <= 1'b1;
      @(posedge clk_sys_i);
      ld <= 1'b0;
      wr(3'h1, 8'h08);
      wr(3'h3, 8'h3C);
      wt(3'h5, 8'h01, 8'h01);
      rchk(3'h1, 8'h08, 8'h00);
      rchk(3'h2, 8'h01, 8'h01);
      rchk(3'h0, 8'h80, 8'h80);
      rchk(3'h0, 8'h40, (i == 2) ? 8'h40 : 8'h00);
      lines(2'b10);
      wr(3'h5, 8'h01);
      wr(3'h0, 8'h21);
      if (i == 0) rchk(3'h3, 8'hFF, tbl[0]);
      if (i == 2) rd(3'h3);
      if (i != 1) rchk(3'h2, 8'h01, 8'h00);
    end
    $display("test receive done");
    wr(3'h1, 8'h10);
    wr(3'h3, 8'h3C);
    wt(3'h1, 8'h10, 8'h00);
    rchk(3'h5, 8'h01, 8'h01);
    rchk(3'h0, 8'h80, 8'h80);
    wr(3'h5, 8'h09);
    wr(3'h0, 8'h21);
    wr(3'h1, 8'h04);
    wr(3'h3, 8'h3C);
    wt(3'h1, 8'h04, 8'h00);
    rchk(3'h2, 8'h10, 8'h10);
    rchk(3'h5, 8'h01, 8'h01);
    rchk(3'h0, 8'h80, 8'h80);
    chk({6'h00, sda_w, scl_w}, 8'h03);
    wr(3'h5, 8'h09);
    wr(3'h0, 8'h21);
    $display("test ack and stop done");
    wr(3'h1, 8'h01);
    wt(3'h1, 8'h01, 8'h00);
    lines(2'b00);
    wr(3'h5, 8'h01);
    wr(3'h1, 8'h02);
    wt(3'h5, 8'h01, 8'h01);
    rchk(3'h1, 8'h02, 8'h00);
    lines(2'b00);
    wr(3'h3, 8'hFF);
    fsda <= 1'b1;
    wt(3'h5, 8'h08, 8'h08);
    rchk(3'h2, 8'h01, 8'h00);
    lines(2'b11);
    wr(3'h5, 8'h09);
    wr(3'h1, 8'h02);
    wt(3'h5, 8'h08, 8'h08);
    rchk(3'h1, 8'h02, 8'h00);
    lines(2'b11);
    wr(3'h5, 8'h09);
    fsda <= 1'b0;
    wt(3'h2, 8'h10, 8'h10);
    fsda <= 1'b1;
    wr(3'h1, 8'h30);
    wt(3'h5, 8'h08, 8'h08);
    rchk(3'h1, 8'h1F, 8'h00);
    lines(2'b11);
    wr(3'h5, 8'h09);
    fsda <= 1'b0;
    wt(3'h5, 8'h01, 8'h01);
    wr(3'h5, 8'h09);
    fscl <= 1'b1;
    wr(3'h1, 8'h01);
    wt(3'h5, 8'h08, 8'h08);
    rchk(3'h1, 8'h01, 8'h00);
    fscl <= 1'b0;
    $display("test collision done");
    wr(3'h0, 8'h00);
    rchk(3'h2, 8'h18, 8'h00);
    wr(3'h0, 8'h21);
    wr(3'h1, 8'h08);
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b1;
    @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1 lines(2'b11);
    rchk(3'h0, 8'hFF, 8'h00);
    rchk(3'h1, 8'h1F, 8'h00);
    $display("test disable and reset done");
    print_verdict();
  end
endmodule // i2cm_core_tb
bind i2cm_core i2cm_sva i_i2cm_sva (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o));
`default_nettype wire
